// >>> shared/dqx_pkg.sv
package dqx_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PTR_W  = 3;

  localparam logic [ADDR_W-1:0] CMP_B_DIR_EXT_ADDR       = 4'h0;
  localparam logic [ADDR_W-1:0] CMP_C_DIR_EXT_ADDR       = 4'h1;
  localparam logic [ADDR_W-1:0] TRACE_WORD_EXT_INFO_ADDR = 4'h2;

  localparam int DIR_EN_BIT     = 7;
  localparam int DIR_VAL_BIT    = 6;
  localparam int PAGED_FLAG_BIT = 7;
  localparam int ADDR_MSB_BIT   = 0;
  localparam int PAGE_MSB_BIT   = 2;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RESET = 3'h0;
  localparam logic [PTR_W-1:0]  PTR_STEP  = 3'h1;

  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  typedef struct packed {
    logic paged;
    logic addr_msb;
  } dqx_ext_s;

  localparam dqx_ext_s EXT_RESET = '{paged: 1'b0, addr_msb: 1'b0};

  typedef struct packed {
    logic dir_enable;
    logic dir_value;
  } dqx_dir_s;

  localparam dqx_dir_s DIR_RESET = '{dir_enable: 1'b0, dir_value: 1'b0};

  typedef enum logic [1:0] {
    DQX_RST_NONE,
    DQX_RST_CLEAR,
    DQX_RST_KEEP
  } dqx_rst_e;

endpackage

// >>> shared/dqx_mem_if.sv
interface dqx_mem_if;
  import dqx_pkg::*;

  logic                 wr_en;
  logic [PTR_W-1:0]     wr_ptr;
  dqx_ext_s             wr_data;
  logic [PTR_W-1:0]     rd_ptr;
  dqx_ext_s             rd_data;

  modport ctrl (
    output wr_en,
    output wr_ptr,
    output wr_data,
    output rd_ptr,
    input  rd_data
  );

  modport mem (
    input  wr_en,
    input  wr_ptr,
    input  wr_data,
    input  rd_ptr,
    output rd_data
  );
endinterface

// >>> design/dqx_ext_mem.sv
module dqx_ext_mem (
  input  wire logic clk_i,
  dqx_mem_if.mem    port_if
);
  import dqx_pkg::*;

  localparam int DEPTH = 1 << PTR_W;

  dqx_ext_s store [DEPTH];

  // contents carry no reset; the read register in front of software does
  always_ff @(posedge clk_i) begin
    if (port_if.wr_en) begin
      store[port_if.wr_ptr] <= port_if.wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    port_if.rd_data <= store[port_if.rd_ptr];
  end

endmodule

// >>> design/dqx_rw_qual_ext.sv
// Chosen here: the strobed register port and the placing of the registers.
module dqx_rw_qual_ext (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [dqx_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [dqx_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [dqx_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic                  end_run_rst_i,
  input  wire logic                  end_trace_rst_i,
  input  wire logic                  trace_module_enable_i,
  input  wire logic                  begin_trigger_i,
  input  wire logic                  full_mode_i,
  input  wire logic                  cmp_a_dir_enable_i,
  input  wire logic                  cmp_a_dir_value_i,
  input  wire logic                  cpu_rw_i,
  input  wire logic                  cmp_b_addr_hit_i,
  input  wire logic                  cmp_c_addr_hit_i,
  input  wire logic                  capture_i,
  input  wire logic                  event_only_i,
  input  wire logic                  ppage_sel_i,
  input  wire logic [2:0]            ppage_i,
  input  wire logic [dqx_pkg::PTR_W-1:0] fifo_rd_ptr_i,
  output logic                       cmp_b_match_o,
  output logic                       cmp_c_match_o,
  output logic                       paged_access_flag_o,
  output logic                       ext_addr_msb_o
);
  import dqx_pkg::*;

  dqx_dir_s         cmp_b_dir;
  dqx_dir_s         cmp_c_dir;
  dqx_ext_s         ext_info;
  logic [PTR_W-1:0] wr_ptr;
  dqx_rst_e         soft_rst;
  dqx_ext_s         next_capture;

  localparam int DEPTH = 1 << PTR_W;

  logic [DEPTH-1:0] word_filled;
  logic             rd_filled;

  dqx_mem_if mem_if ();

  // direction qualifier shared by both comparators
  function automatic logic dir_ok(input dqx_dir_s dir, input logic rw);
    dir_ok = !dir.dir_enable || (dir.dir_value == rw);
  endfunction

  function automatic logic [DATA_W-1:0] pack_dir(input dqx_dir_s dir);
    logic [DATA_W-1:0] val;
    val              = READ_ZERO;
    val[DIR_EN_BIT]  = dir.dir_enable;
    val[DIR_VAL_BIT] = dir.dir_value;
    pack_dir         = val;
  endfunction

  // end-run contents may be anything, so clearing is the cheapest safe choice
  always_comb begin
    if (end_run_rst_i) begin
      soft_rst = DQX_RST_CLEAR;
    end else if (end_trace_rst_i) begin
      if (trace_module_enable_i && !begin_trigger_i) begin
        soft_rst = DQX_RST_KEEP;
      end else begin
        soft_rst = DQX_RST_CLEAR;
      end
    end else begin
      soft_rst = DQX_RST_NONE;
    end
  end

  // direction-qualifier registers, software written
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_b_dir <= DIR_RESET;
      cmp_c_dir <= DIR_RESET;
    end else begin
      case (soft_rst)
        DQX_RST_CLEAR: begin
          cmp_b_dir <= DIR_RESET;
          cmp_c_dir <= DIR_RESET;
        end
        DQX_RST_KEEP: begin
          cmp_b_dir <= cmp_b_dir;
          cmp_c_dir <= cmp_c_dir;
        end
        DQX_RST_NONE: begin
          if (reg_wr_i && reg_addr_i == CMP_B_DIR_EXT_ADDR) begin
            cmp_b_dir.dir_enable <= reg_wdata_i[DIR_EN_BIT];
            cmp_b_dir.dir_value  <= reg_wdata_i[DIR_VAL_BIT];
          end
          if (reg_wr_i && reg_addr_i == CMP_C_DIR_EXT_ADDR) begin
            cmp_c_dir.dir_enable <= reg_wdata_i[DIR_EN_BIT];
            cmp_c_dir.dir_value  <= reg_wdata_i[DIR_VAL_BIT];
          end
        end
        default: begin
          cmp_b_dir <= DIR_RESET;
          cmp_c_dir <= DIR_RESET;
        end
      endcase
    end
  end

  // match qualification; full modes hand comparator B over to A's bits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_b_match_o <= 1'b0;
      cmp_c_match_o <= 1'b0;
    end else begin
      if (full_mode_i) begin
        cmp_b_match_o <= cmp_b_addr_hit_i &&
                         dir_ok('{dir_enable: cmp_a_dir_enable_i,
                                  dir_value:  cmp_a_dir_value_i}, cpu_rw_i);
      end else begin
        cmp_b_match_o <= cmp_b_addr_hit_i && dir_ok(cmp_b_dir, cpu_rw_i);
      end
      cmp_c_match_o <= cmp_c_addr_hit_i && dir_ok(cmp_c_dir, cpu_rw_i);
    end
  end

  // extension captured beside each stored trace word
  always_comb begin
    next_capture = EXT_RESET;
    if (!event_only_i && ppage_sel_i) begin
      next_capture.paged    = 1'b1;
      next_capture.addr_msb = ppage_i[PAGE_MSB_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= PTR_RESET;
    end else begin
      case (soft_rst)
        DQX_RST_CLEAR: wr_ptr <= PTR_RESET;
        DQX_RST_KEEP:  wr_ptr <= wr_ptr;
        DQX_RST_NONE: begin
          if (capture_i) begin
            wr_ptr <= wr_ptr + PTR_STEP;
          end
        end
        default: wr_ptr <= PTR_RESET;
      endcase
    end
  end

  // the store has no reset, so a word not captured since the last clear reads as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_filled <= '0;
    end else begin
      case (soft_rst)
        DQX_RST_CLEAR: word_filled <= '0;
        DQX_RST_KEEP:  word_filled <= word_filled;
        DQX_RST_NONE: begin
          if (capture_i) begin
            word_filled[wr_ptr] <= 1'b1;
          end
        end
        default: word_filled <= '0;
      endcase
    end
  end

  // lines up with the registered read data of the store
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_filled <= 1'b0;
    end else if (soft_rst == DQX_RST_CLEAR) begin
      rd_filled <= 1'b0;
    end else begin
      rd_filled <= word_filled[fifo_rd_ptr_i];
    end
  end

  assign mem_if.wr_en   = capture_i && (soft_rst == DQX_RST_NONE);
  assign mem_if.wr_ptr  = wr_ptr;
  assign mem_if.wr_data = next_capture;
  // read pointer is owned by the trace word store; the low-byte read moves it
  assign mem_if.rd_ptr  = fifo_rd_ptr_i;

  dqx_ext_mem u_ext_mem (
    .clk_i   (clk_i),
    .port_if (mem_if.mem)
  );

  // visible extension follows the word at the read pointer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_info <= EXT_RESET;
    end else begin
      case (soft_rst)
        DQX_RST_CLEAR: ext_info <= EXT_RESET;
        DQX_RST_KEEP:  ext_info <= ext_info;
        DQX_RST_NONE:  ext_info <= rd_filled ? mem_if.rd_data : EXT_RESET;
        default:       ext_info <= EXT_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      paged_access_flag_o <= 1'b0;
      ext_addr_msb_o      <= 1'b0;
    end else begin
      paged_access_flag_o <= ext_info.paged;
      ext_addr_msb_o      <= ext_info.addr_msb;
    end
  end

  // register read port; unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= READ_ZERO;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CMP_B_DIR_EXT_ADDR: reg_rdata_o <= pack_dir(cmp_b_dir);
        CMP_C_DIR_EXT_ADDR: reg_rdata_o <= pack_dir(cmp_c_dir);
        TRACE_WORD_EXT_INFO_ADDR: begin
          reg_rdata_o                 <= READ_ZERO;
          reg_rdata_o[PAGED_FLAG_BIT] <= ext_info.paged;
          reg_rdata_o[ADDR_MSB_BIT]   <= ext_info.addr_msb;
        end
        default: reg_rdata_o <= READ_ZERO;
      endcase
    end else begin
      reg_rdata_o <= READ_ZERO;
    end
  end

endmodule

// >>> tb/dqx_cpu_model.sv
module dqx_cpu_model (
  input  wire logic       clk_i,
  output logic      [8:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus_o = 9'h000;
  // bus word: rw, hit b, hit c, capture, event only, paged select, page
  // on release direction and page turn over, so a stale value never looks valid
  task automatic cycle(input logic [8:0] v);
    @(posedge clk_i);
    bus_o <= v;
    @(posedge clk_i);
    bus_o <= {~v[8], 3'h0, v[4:3], ~v[2:0]};
  endtask
endmodule

// >>> tb/dqx_rw_qual_ext_checker.sv
module dqx_rw_qual_ext_checker import dqx_pkg::*; (
  input logic              clk_i,
  input logic              rst_n_i,
  input logic [ADDR_W-1:0] reg_addr_i,
  input logic              reg_rd_i,
  input logic [DATA_W-1:0] reg_rdata_o,
  input logic              full_mode_i,
  input logic              cmp_a_dir_enable_i,
  input logic              cmp_a_dir_value_i,
  input logic              cpu_rw_i,
  input logic              cmp_b_addr_hit_i,
  input logic              cmp_c_addr_hit_i,
  input logic              cmp_b_match_o,
  input logic              cmp_c_match_o,
  input logic              paged_access_flag_o,
  input logic              ext_addr_msb_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence a_wrong_s;
    full_mode_i && cmp_a_dir_enable_i && cpu_rw_i != cmp_a_dir_value_i;
  endsequence
  sequence ext_rd_s;
    $past(reg_rd_i && reg_addr_i == TRACE_WORD_EXT_INFO_ADDR);
  endsequence
  reset_zero_a: assert property (disable iff (1'b0)
    !rst_n_i |-> !paged_access_flag_o && reg_rdata_o == REG_RESET) else $error("set in reset");
  b_full_a: assert property (a_wrong_s |=> !cmp_b_match_o) else $error("b dir");
  a_off_a: assert property (full_mode_i && !cmp_a_dir_enable_i && cmp_b_addr_hit_i
    |=> cmp_b_match_o) else $error("a dir");
  b_hit_a: assert property (cmp_b_match_o |-> $past(cmp_b_addr_hit_i)) else $error("b hit");
  c_hit_a: assert property (cmp_c_match_o |-> $past(cmp_c_addr_hit_i)) else $error("c hit");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == READ_ZERO) else $error("rd");
  ext_rd_a: assert property (ext_rd_s |-> reg_rdata_o == {paged_access_flag_o, 6'h00,
    ext_addr_msb_o}) else $error("ext info");
  msb_a: assert property (!paged_access_flag_o |-> !ext_addr_msb_o) else $error("msb");
endmodule

bind dqx_rw_qual_ext dqx_rw_qual_ext_checker u_chk (.clk_i, .rst_n_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .full_mode_i, .cmp_a_dir_enable_i, .cmp_a_dir_value_i, .cpu_rw_i,
  .cmp_b_addr_hit_i, .cmp_c_addr_hit_i, .cmp_b_match_o, .cmp_c_match_o, .paged_access_flag_o,
  .ext_addr_msb_o);

// >>> tb/dqx_rw_qual_ext_bench.sv
module dqx_rw_qual_ext_bench import dqx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_n_i, reg_wr_i = 1'b0, reg_rd_i = 1'b0, end_run_rst_i = 1'b0;
  logic end_trace_rst_i = 1'b0, trace_module_enable_i = 1'b1, begin_trigger_i = 1'b0;
  logic full_mode_i = 1'b0, cmp_a_dir_enable_i = 1'b0, cmp_a_dir_value_i = 1'b0;
  logic cpu_rw_i, cmp_b_addr_hit_i, cmp_c_addr_hit_i, capture_i, event_only_i, ppage_sel_i;
  logic cmp_b_match_o, cmp_c_match_o, paged_access_flag_o, ext_addr_msb_o;
  logic [2:0] ppage_i;
  logic [8:0] bus;
  logic [PTR_W-1:0] fifo_rd_ptr_i = PTR_RESET;
  logic [ADDR_W-1:0] reg_addr_i = 4'h0;
  logic [DATA_W-1:0] reg_wdata_i = 8'h00, reg_rdata_o;
  int miscompares = 0, comparisons = 0;
  assign {cpu_rw_i, cmp_b_addr_hit_i, cmp_c_addr_hit_i, capture_i, event_only_i, ppage_sel_i,
    ppage_i} = bus;
  always #50 clk_i = ~clk_i;
  dqx_rw_qual_ext DUT (.*);
  dqx_cpu_model cpu (.clk_i, .bus_o(bus));
  task automatic chk(string n, logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, string n);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(n, e, reg_rdata_o);
  endtask
  task automatic t_access();
    for (int a = 0; a < 3; a++)
      rd(a[3:0], REG_RESET, "reset value");
    for (int a = 0; a < 3; a++)
      wr(a[3:0], 8'hFF);
    rd(CMP_B_DIR_EXT_ADDR, 8'hC0, "b ext");
    rd(CMP_C_DIR_EXT_ADDR, 8'hC0, "c ext");
    rd(TRACE_WORD_EXT_INFO_ADDR, READ_ZERO, "ext info");
    rd(4'hF, READ_ZERO, "unmapped");
    $display("access test done");
  endtask
  // in full mode the b bits are set opposite to the a bits, so using them shows up
  task automatic t_match();
    logic [2:0] i;
    logic [7:0] e;
    for (int n = 0; n < 16; n++) begin
      i = n[2:0];
      full_mode_i <= n[3];
      {cmp_a_dir_enable_i, cmp_a_dir_value_i} <= i[2:1];
      wr(CMP_B_DIR_EXT_ADDR, {i[2:1] ^ {2{n[3]}}, 6'h00});
      wr(CMP_C_DIR_EXT_ADDR, {i[2:1], 6'h00});
      cpu.cycle({i[0], 8'hC0});
      e = {7'h00, !i[2] | i[0] == i[1]};
      #1 chk("b match", e, {7'h00, cmp_b_match_o});
      chk("c match", e, {7'h00, cmp_c_match_o});
    end
    $display("match test done");
  endtask
  task automatic t_capture();
    logic [4:0] s [4] = '{5'h0C, 5'h0B, 5'h1F, 5'h07};
    logic [7:0] e [4] = '{8'h81, 8'h80, 8'h00, 8'h00};
    for (int p = 0; p < 4; p++)
      cpu.cycle({4'h9, s[p]});
    for (int p = 0; p < 4; p++) begin
      fifo_rd_ptr_i <= p[PTR_W-1:0];
      repeat (4) @(posedge clk_i);
      #1 chk("paged", {7'h00, e[p][7]}, {7'h00, paged_access_flag_o});
      chk("bit 16", {7'h00, e[p][0]}, {7'h00, ext_addr_msb_o});
      rd(TRACE_WORD_EXT_INFO_ADDR, e[p], "ext info");
    end
    $display("capture test done");
  endtask
  // end-trace with enable and no begin keeps state; with begin it clears; end-run clears
  task automatic t_soft();
    fifo_rd_ptr_i <= PTR_RESET;
    for (int r = 0; r < 3; r++) begin
      wr(CMP_C_DIR_EXT_ADDR, 8'h40);
      cpu.cycle({4'h9, 5'h0C});
      @(posedge clk_i);
      begin_trigger_i <= (r == 1);
      {end_run_rst_i, end_trace_rst_i} <= (r == 2) ? 2'b10 : 2'b01;
      @(posedge clk_i);
      {end_run_rst_i, end_trace_rst_i} <= 2'b00;
      begin_trigger_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      rd(CMP_C_DIR_EXT_ADDR, r ? REG_RESET : 8'h40, "soft reset");
      chk("soft paged", {7'h00, r == 0}, {7'h00, paged_access_flag_o});
    end
    $display("soft reset test done");
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_access();
    t_match();
    t_capture();
    t_soft();
    results();
  end
  // the tests need well under a thousand cycles; ten thousand leaves ample margin
  initial begin
    #1000000;
    miscompares++;
    results();
  end
endmodule
